/* File: rsx_exec.sv */
// Behaviour
// RL1: Rotate right without carry: bit n to n-1, bit 0 to bit 7; only N, Z.
// RL2: Destination bit 0 writes W, 1 writes back to the addressed register.
// RL3: Access bit 0 uses the access bank, 1 uses the bank select register.
// RL4: Access bit 0 with extended set: offsets up to 5Fh are indexed literal offsets.
// RL5: Set-all-ones writes FFh to the register, flags untouched, access bit honoured.
// RL6: Sleep opcode stops the oscillator, entering sleep in the fourth quarter.
// RL7: Sleep sets the timeout flag to one.
// RL8: Sleep clears the powerdown flag; no flag other than timeout and powerdown changes.
// RL9: Sleep clears the watchdog counter and its postscaler.
// RL10: A watchdog wake-up from sleep clears the timeout flag.
// RL11: Subtract with borrow: W minus register minus inverted carry, routed by d and a.
// RL12: Subtract with borrow updates N, OV, C, DC, Z; carry means no borrow.
// RL13: Subtract from literal: literal minus W into W, same flag updates.
// RL14: Each instruction is one word over four quarters: decode, read, process, write.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rsx_exec #(
	parameter int unsigned DATA_W = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	// Plain register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Instruction input
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	output logic instr_ready_o,
	output logic instr_done_o,
	// Data memory
	output logic mem_rd_o,
	output logic [11:0] mem_addr_o,
	input wire logic [7:0] mem_rdata_i,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	// Power and watchdog
	input wire logic wake_i,
	input wire logic wdt_wake_i,
	output logic osc_stop_o,
	output logic wdt_clear_o
);

	rsx_pkg::rsx_phase_e phase_q;
	rsx_pkg::rsx_op_e op_q;
	logic [15:0] instr_q;
	logic [7:0] ctrl_q;
	logic [3:0] bank_q;
	logic [7:0] work_q;
	logic [6:0] status_q;
	logic [11:0] index_q;
	logic [11:0] addr_q;
	logic [7:0] res_q;
	logic [6:0] flags_q;
	logic dest_w_q;
	logic dest_f_q;
	logic sleep_q;
	logic [7:0] rdata_q;
	logic [12:0] sub_res;
	logic [7:0] sub_a;
	logic [7:0] sub_b;
	logic sub_borrow;

	// Opcode decode; unknown words fall through as a four-quarter no-op
	function automatic rsx_pkg::rsx_op_e decode_op(input logic [15:0] w);
		if (w == rsx_pkg::OPC_SLEEP)
			decode_op = rsx_pkg::SLEEP_OP;
		else if (w[15:10] == rsx_pkg::OPC_ROT)
			decode_op = rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP;
		else if (w[15:9] == rsx_pkg::OPC_SET)
			decode_op = rsx_pkg::SET_ALL_ONES_OP;
		else if (w[15:10] == rsx_pkg::OPC_SUBB)
			decode_op = rsx_pkg::SUBTRACT_REG_BORROW_FROM_W_OP;
		else if (w[15:8] == rsx_pkg::OPC_SUBL)
			decode_op = rsx_pkg::SUBTRACT_W_FROM_LITERAL_OP;
		else
			decode_op = rsx_pkg::OP_NONE;
	endfunction : decode_op

	// Two's complement a - b - borrow; returns {N, OV, Z, DC, C, result}
	function automatic logic [12:0] sub_calc(input logic [7:0] a, input logic [7:0] b, input logic bw);
		logic [8:0] full;
		logic [4:0] nib;
		logic [7:0] r;
		full = {1'b0, a} - {1'b0, b} - {8'h00, bw};
		nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
		r = full[7:0];
		sub_calc = {r[7], (a[7] ^ b[7]) & (a[7] ^ r[7]), r == 8'h00, ~nib[4], ~full[8], r};
	endfunction : sub_calc

	// Operand address: access bank, indexed offset, or banked
	function automatic logic [11:0] calc_addr(input logic [7:0] f, input logic a_bit, input logic ext,
		input logic [3:0] bank, input logic [11:0] base);
		if (a_bit)
			calc_addr = {bank, f}; // RL3
		else if (ext && (f <= rsx_pkg::INDEX_MAX))
			calc_addr = base + {4'h0, f}; // RL4
		else if (f <= rsx_pkg::INDEX_MAX)
			calc_addr = {rsx_pkg::ACCESS_LO_BANK, f}; // RL3
		else
			calc_addr = {rsx_pkg::ACCESS_HI_BANK, f};
	endfunction : calc_addr

	// Quarter sequencer; a new word is taken only from idle and never in sleep
	assign instr_ready_o = (phase_q == rsx_pkg::PH_IDLE) && !sleep_q;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			phase_q <= rsx_pkg::PH_IDLE;
		else
		begin
			case (phase_q) // RL14
				rsx_pkg::PH_IDLE: if (instr_valid_i && !sleep_q) phase_q <= rsx_pkg::PH_Q1;
				rsx_pkg::PH_Q1: phase_q <= rsx_pkg::PH_Q2;
				rsx_pkg::PH_Q2: phase_q <= rsx_pkg::PH_Q3;
				rsx_pkg::PH_Q3: phase_q <= rsx_pkg::PH_Q4;
				rsx_pkg::PH_Q4: phase_q <= rsx_pkg::PH_IDLE;
				default: phase_q <= rsx_pkg::PH_IDLE;
			endcase
		end
	end

	// Latch the word and decode it as it is taken in idle, ready for the first quarter
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			instr_q <= 16'h0000;
			op_q <= rsx_pkg::OP_NONE;
		end
		else if (instr_ready_o && instr_valid_i)
		begin
			instr_q <= instr_i;
			op_q <= decode_op(instr_i);
		end
	end

	// Address and destination are settled in Q1 so the read can go out in Q2
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			addr_q <= 12'h000;
			dest_w_q <= 1'b0;
			dest_f_q <= 1'b0;
		end
		else if (phase_q == rsx_pkg::PH_Q1)
		begin
			addr_q <= calc_addr(instr_q[7:0], instr_q[8], ctrl_q[rsx_pkg::CTRL_EXT_BIT], bank_q, index_q);
			case (op_q)
				rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP, rsx_pkg::SUBTRACT_REG_BORROW_FROM_W_OP:
				begin
					dest_w_q <= !instr_q[9]; // RL2
					dest_f_q <= instr_q[9]; // RL2
				end
				rsx_pkg::SET_ALL_ONES_OP:
				begin
					dest_w_q <= 1'b0;
					dest_f_q <= 1'b1; // RL5
				end
				rsx_pkg::SUBTRACT_W_FROM_LITERAL_OP:
				begin
					dest_w_q <= 1'b1; // RL13
					dest_f_q <= 1'b0;
				end
				default:
				begin
					dest_w_q <= 1'b0;
					dest_f_q <= 1'b0;
				end
			endcase
		end
	end

	// Operand read in Q2; memory answers one cycle later, in Q3
	assign mem_rd_o = (phase_q == rsx_pkg::PH_Q2) &&
		(op_q == rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP || op_q == rsx_pkg::SUBTRACT_REG_BORROW_FROM_W_OP);
	assign mem_addr_o = addr_q;

	// Subtractor operands; the literal form has no incoming borrow
	always_comb
	begin
		if (op_q == rsx_pkg::SUBTRACT_W_FROM_LITERAL_OP)
		begin
			sub_a = instr_q[7:0]; // RL13
			sub_b = work_q;
			sub_borrow = 1'b0;
		end
		else
		begin
			sub_a = work_q; // RL11
			sub_b = mem_rdata_i;
			sub_borrow = !status_q[rsx_pkg::ST_C]; // RL11
		end
		sub_res = sub_calc(sub_a, sub_b, sub_borrow);
	end

	// Q3: process data into the result and the next flag set
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			res_q <= 8'h00;
			flags_q <= rsx_pkg::STATUS_RST;
		end
		else if (phase_q == rsx_pkg::PH_Q3)
		begin
			res_q <= 8'h00;
			flags_q <= status_q;
			case (op_q)
				rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP:
				begin
					res_q <= {mem_rdata_i[0], mem_rdata_i[7:1]}; // RL1
					flags_q[rsx_pkg::ST_N] <= mem_rdata_i[0]; // RL1
					flags_q[rsx_pkg::ST_Z] <= mem_rdata_i == 8'h00; // RL1
				end
				rsx_pkg::SET_ALL_ONES_OP: res_q <= rsx_pkg::ALL_ONES; // RL5
				rsx_pkg::SLEEP_OP:
				begin
					flags_q[rsx_pkg::ST_TO] <= 1'b1; // RL7
					flags_q[rsx_pkg::ST_PD] <= 1'b0; // RL8
				end
				rsx_pkg::SUBTRACT_REG_BORROW_FROM_W_OP, rsx_pkg::SUBTRACT_W_FROM_LITERAL_OP:
				begin
					res_q <= sub_res[7:0]; // RL11
					flags_q[rsx_pkg::ST_C] <= sub_res[8]; // RL12
					flags_q[rsx_pkg::ST_DC] <= sub_res[9]; // RL12
					flags_q[rsx_pkg::ST_Z] <= sub_res[10]; // RL12
					flags_q[rsx_pkg::ST_OV] <= sub_res[11]; // RL12
					flags_q[rsx_pkg::ST_N] <= sub_res[12]; // RL12
				end
				default: res_q <= 8'h00;
			endcase
		end
	end

	// Q4: write to destination
	assign mem_wr_o = (phase_q == rsx_pkg::PH_Q4) && dest_f_q; // RL2
	assign mem_wdata_o = res_q;
	assign instr_done_o = phase_q == rsx_pkg::PH_Q4;
	assign wdt_clear_o = (phase_q == rsx_pkg::PH_Q4) && (op_q == rsx_pkg::SLEEP_OP); // RL9

	// Sleep is a level until any wake source; the clock tree reads it as stop
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			sleep_q <= 1'b0;
		else if ((phase_q == rsx_pkg::PH_Q4) && (op_q == rsx_pkg::SLEEP_OP))
			sleep_q <= 1'b1; // RL6
		else if (sleep_q && (wake_i || wdt_wake_i))
			sleep_q <= 1'b0;
	end
	assign osc_stop_o = sleep_q; // RL6

	// Control, bank and index registers are software only
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctrl_q <= rsx_pkg::CTRL_RST;
			bank_q <= rsx_pkg::BANK_RST;
			index_q <= rsx_pkg::INDEX_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == rsx_pkg::REG_CTRL)
				ctrl_q <= {7'h00, reg_wdata_i[rsx_pkg::CTRL_EXT_BIT]};
			if (reg_addr_i == rsx_pkg::REG_BANK)
				bank_q <= reg_wdata_i[3:0];
			if (reg_addr_i == rsx_pkg::REG_INDEX)
				index_q <= {4'h0, reg_wdata_i};
		end
	end

	// Working register; the instruction write wins over a software write
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			work_q <= rsx_pkg::WORK_RST;
		else if ((phase_q == rsx_pkg::PH_Q4) && dest_w_q)
			work_q <= res_q; // RL2
		else if (reg_wr_i && (reg_addr_i == rsx_pkg::REG_WORK))
			work_q <= reg_wdata_i;
	end

	// Status: instruction update, then watchdog wake, then software
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			status_q <= rsx_pkg::STATUS_RST;
		else if (phase_q == rsx_pkg::PH_Q4)
			status_q <= flags_q; // RL8
		else if (sleep_q && wdt_wake_i)
			status_q[rsx_pkg::ST_TO] <= 1'b0; // RL10
		else if (reg_wr_i && (reg_addr_i == rsx_pkg::REG_STATUS))
			status_q <= reg_wdata_i[6:0];
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_q <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				rsx_pkg::REG_CTRL: rdata_q <= ctrl_q;
				rsx_pkg::REG_BANK: rdata_q <= {4'h0, bank_q};
				rsx_pkg::REG_WORK: rdata_q <= work_q;
				rsx_pkg::REG_STATUS: rdata_q <= {1'b0, status_q};
				rsx_pkg::REG_INDEX: rdata_q <= index_q[7:0];
				rsx_pkg::REG_STATE: rdata_q <= {4'h0, sleep_q, phase_q};
				default: rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end
	assign reg_rdata_o = rdata_q;

	rotate_result_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL1
		(phase_q == rsx_pkg::PH_Q3 && op_q == rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP)
		|=> res_q == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])})
		else $error("rotate result wrong");

	dest_select_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL2
		(phase_q == rsx_pkg::PH_Q1 && op_q == rsx_pkg::ROTATE_RIGHT_NO_CARRY_OP)
		|=> ##2 (mem_wr_o == instr_q[9]))
		else $error("destination select wrong");

	bank_pick_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL3
		(phase_q == rsx_pkg::PH_Q1 && instr_q[8] && op_q != rsx_pkg::SLEEP_OP)
		|=> mem_addr_o == {$past(bank_q), $past(instr_q[7:0])})
		else $error("banked address wrong");

	set_all_ones_op_ones_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL5
		(phase_q == rsx_pkg::PH_Q4 && op_q == rsx_pkg::SET_ALL_ONES_OP)
		|-> mem_wr_o && mem_wdata_o == 8'hFF ##1 $stable(status_q))
		else $error("set all ones wrong");

	sleep_entry_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL6
		(phase_q == rsx_pkg::PH_Q4 && op_q == rsx_pkg::SLEEP_OP)
		|-> wdt_clear_o ##1 (osc_stop_o && status_q[rsx_pkg::ST_TO] && !status_q[rsx_pkg::ST_PD]))
		else $error("sleep entry wrong");

	sleep_flags_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL8
		(phase_q == rsx_pkg::PH_Q4 && op_q == rsx_pkg::SLEEP_OP)
		|=> status_q[4:0] == $past(status_q[4:0]))
		else $error("sleep touched other flags");

	wdt_wake_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL10
		(sleep_q && wdt_wake_i && phase_q == rsx_pkg::PH_IDLE)
		|=> !status_q[rsx_pkg::ST_TO] && !osc_stop_o)
		else $error("watchdog wake did not clear timeout");

	sub_carry_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL12
		(phase_q == rsx_pkg::PH_Q3 && op_q == rsx_pkg::SUBTRACT_REG_BORROW_FROM_W_OP)
		|=> ##1 status_q[rsx_pkg::ST_C] == ({1'b0, $past(work_q, 2)} >=
			{1'b0, $past(mem_rdata_i, 2)} + {8'h00, !$past(status_q[rsx_pkg::ST_C], 2)}))
		else $error("borrow carry wrong");

	subtract_w_from_literal_op_dest_a: assert property (@(posedge clk_i) disable iff (srst_i) // RL13
		(phase_q == rsx_pkg::PH_Q3 && op_q == rsx_pkg::SUBTRACT_W_FROM_LITERAL_OP)
		|=> ##1 work_q == 8'($past(instr_q[7:0], 2) - $past(work_q, 2)) && !$past(mem_wr_o))
		else $error("literal subtract wrong");

endmodule : rsx_exec
`default_nettype wire

/* File: rsx_pkg.sv */
`default_nettype none
package rsx_pkg;
	// Register map of the execution slice, byte offsets on the plain port
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BANK = 8'h04;
	localparam logic [7:0] REG_WORK = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_INDEX = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;

	// Control field and reset values
	localparam int CTRL_EXT_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [11:0] INDEX_RST = 12'h000;

	// Status field positions; timeout and powerdown come out of reset high
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	localparam int ST_PD = 5;
	localparam int ST_TO = 6;
	localparam logic [6:0] STATUS_RST = 7'h60;

	// Opcode patterns
	localparam logic [5:0] OPC_ROT = 6'h10;
	localparam logic [6:0] OPC_SET = 7'h34;
	localparam logic [5:0] OPC_SUBB = 6'h15;
	localparam logic [7:0] OPC_SUBL = 8'h08;
	localparam logic [15:0] OPC_SLEEP = 16'h0003;

	// Access bank split and indexed offset limit
	localparam logic [7:0] INDEX_MAX = 8'h5F;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	typedef enum logic [2:0] {
		OP_NONE,
		ROTATE_RIGHT_NO_CARRY_OP,
		SET_ALL_ONES_OP,
		SLEEP_OP,
		SUBTRACT_REG_BORROW_FROM_W_OP,
		SUBTRACT_W_FROM_LITERAL_OP
	} rsx_op_e;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} rsx_phase_e;
endpackage : rsx_pkg
`default_nettype wire

/* File: rsx_exec_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [15:0] word;
		logic [7:0] w0, st0, opnd;
		logic wr;
		logic [7:0] wd, ew, est;
		logic chka;
		logic [11:0] addr;
	} rsx_row_s;

	logic clk_i, srst_i, reg_wr_i, reg_rd_i, instr_valid_i, wake_i, wdt_wake_i;
	logic [7:0] reg_addr_i, reg_wdata_i, mem_rdata_i, reg_rdata_o, mem_wdata_o;
	logic [15:0] instr_i;
	logic [11:0] mem_addr_o;
	logic instr_ready_o, instr_done_o, mem_rd_o, mem_wr_o, osc_stop_o, wdt_clear_o;
	int fail_count, tests_run, c_k;
	logic c_wr, c_clr, c_rd;
	logic [7:0] c_wd;
	logic [11:0] c_addr;

	// Word, W before, status before, operand, write, write data, W after, status after, check address, address
	rsx_row_s rows [13] = '{
		'{16'h4220, 8'h11, 8'h61, 8'hD7, 1'b1, 8'hEB, 8'h11, 8'h71, 1'b1, 12'h020},
		'{16'h4130, 8'h11, 8'h60, 8'h01, 1'b0, 8'h00, 8'h80, 8'h70, 1'b1, 12'h230},
		'{16'h42A0, 8'h11, 8'h70, 8'h00, 1'b1, 8'h00, 8'h11, 8'h64, 1'b1, 12'hFA0},
		'{16'h6955, 8'h11, 8'h7F, 8'h00, 1'b1, 8'hFF, 8'h11, 8'h7F, 1'b1, 12'h255},
		'{16'h6880, 8'h22, 8'h60, 8'h00, 1'b1, 8'hFF, 8'h22, 8'h60, 1'b1, 12'hF80},
		'{16'h5610, 8'h02, 8'h61, 8'h03, 1'b1, 8'hFF, 8'h02, 8'h70, 1'b1, 12'h010},
		'{16'h5440, 8'h05, 8'h61, 8'h02, 1'b0, 8'h00, 8'h03, 8'h63, 1'b1, 12'h040},
		'{16'h5708, 8'h02, 8'h60, 8'h01, 1'b1, 8'h00, 8'h02, 8'h67, 1'b1, 12'h208},
		'{16'h5461, 8'h80, 8'h61, 8'h01, 1'b0, 8'h00, 8'h7F, 8'h69, 1'b1, 12'hF61},
		'{16'h0802, 8'h01, 8'h60, 8'h00, 1'b0, 8'h00, 8'h01, 8'h63, 1'b0, 12'h000},
		'{16'h0802, 8'h02, 8'h60, 8'h00, 1'b0, 8'h00, 8'h00, 8'h67, 1'b0, 12'h000},
		'{16'h0802, 8'h03, 8'h61, 8'h00, 1'b0, 8'h00, 8'hFF, 8'h70, 1'b0, 12'h000},
		'{16'hFFFF, 8'h44, 8'h63, 8'h00, 1'b0, 8'h00, 8'h44, 8'h63, 1'b0, 12'h000}
	};

	rsx_exec DUT (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.instr_ready_o(instr_ready_o),
		.instr_done_o(instr_done_o),
		.mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o),
		.mem_rdata_i(mem_rdata_i),
		.mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o),
		.wake_i(wake_i),
		.wdt_wake_i(wdt_wake_i),
		.osc_stop_o(osc_stop_o),
		.wdt_clear_o(wdt_clear_o)
	);

	// Free-running 250 MHz core clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	// One-cycle strobes; the slave never stalls, so no wait loop is needed
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		// Let an edge pass so a following write never reassigns the strobe in this step
		@(posedge clk_i);
	endtask : wr

	// Read data stand only in the cycle after the strobe, so look there
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
		// Back onto the edge so the next caller drives at a rising edge
		@(posedge clk_i);
	endtask : rd

	// Issue one word and capture the Q4 outputs; the operand is held for the whole instruction
	task automatic exec(input logic [15:0] w, input logic [7:0] opnd);
		instr_valid_i <= 1'b1;
		instr_i <= w;
		mem_rdata_i <= opnd;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		c_k = 1;
		c_rd = 1'b0;
		#1;
		while (instr_done_o !== 1'b1 && c_k < 12)
		begin
			@(posedge clk_i);
			#1;
			c_rd = c_rd | mem_rd_o;
			c_k++;
		end
		c_wr = mem_wr_o;
		c_wd = mem_wdata_o;
		c_addr = mem_addr_o;
		c_clr = wdt_clear_o;
		@(posedge clk_i);
	endtask : exec

	task automatic close_out();
		$display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	// Hang guard, well beyond the few hundred cycles the sequence needs
	initial
	begin
		#(4 * 4000);
		fail_count++;
		close_out();
	end

	// Main sequence: table rows, then addressing, sleep and reset cases
	initial
	begin
		srst_i = 1'b1;
		{reg_wr_i, reg_rd_i, instr_valid_i, wake_i, wdt_wake_i} = 5'h00;
		{reg_addr_i, reg_wdata_i, mem_rdata_i} = 24'h000000;
		instr_i = 16'h0000;
		fail_count = 0;
		tests_run = 0;
		repeat (12) @(posedge clk_i);
		srst_i <= 1'b0;
		wr(rsx_pkg::REG_BANK, 8'h02);
		wr(rsx_pkg::REG_CTRL, 8'h00);
		foreach (rows[i])
		begin
			wr(rsx_pkg::REG_WORK, rows[i].w0);
			wr(rsx_pkg::REG_STATUS, rows[i].st0);
			exec(rows[i].word, rows[i].opnd);
			chk(16'(c_k), 16'h0004);
			chk(c_rd, rows[i].word[15:13] == 3'b010);
			chk(c_wr, rows[i].wr);
			if (rows[i].wr)
				chk(c_wd, rows[i].wd);
			if (rows[i].chka)
				chk(c_addr, rows[i].addr);
			rd(rsx_pkg::REG_WORK, rows[i].ew);
			rd(rsx_pkg::REG_STATUS, rows[i].est);
		end
		// Indexed offsets only with the access bank and the extended set on
		wr(rsx_pkg::REG_CTRL, 8'h01);
		wr(rsx_pkg::REG_INDEX, 8'h40);
		exec(16'h6810, 8'h00);
		chk(c_addr, 12'h050);
		exec(16'h685F, 8'h00);
		chk(c_addr, 12'h09F);
		exec(16'h6860, 8'h00);
		chk(c_addr, 12'hF60);
		exec(16'h6910, 8'h00);
		chk(c_addr, 12'h210);
		wr(rsx_pkg::REG_CTRL, 8'h00);
		// Sleep with every arithmetic flag set, then a watchdog wake
		wr(rsx_pkg::REG_STATUS, 8'h1F);
		exec(16'h0003, 8'h00);
		chk(c_clr, 1'b1);
		chk(16'(c_k), 16'h0004);
		#1;
		chk(osc_stop_o, 1'b1);
		chk(instr_ready_o, 1'b0);
		@(posedge clk_i);
		rd(rsx_pkg::REG_STATUS, 8'h5F);
		rd(rsx_pkg::REG_STATE, 8'h08);
		wdt_wake_i <= 1'b1;
		@(posedge clk_i);
		wdt_wake_i <= 1'b0;
		#1;
		chk(osc_stop_o, 1'b0);
		@(posedge clk_i);
		rd(rsx_pkg::REG_STATUS, 8'h1F);
		// An ordinary wake leaves the timeout flag set
		exec(16'h0003, 8'h00);
		rd(rsx_pkg::REG_STATUS, 8'h5F);
		wake_i <= 1'b1;
		@(posedge clk_i);
		wake_i <= 1'b0;
		#1;
		chk(osc_stop_o, 1'b0);
		@(posedge clk_i);
		rd(rsx_pkg::REG_STATUS, 8'h5F);
		// Mid-run reset while asleep brings the registers back; unmapped places read zero
		exec(16'h0003, 8'h00);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		wr(8'h18, 8'h5A);
		rd(8'h18, 8'h00);
		rd(rsx_pkg::REG_STATUS, {1'b0, rsx_pkg::STATUS_RST});
		rd(rsx_pkg::REG_WORK, rsx_pkg::WORK_RST);
		rd(rsx_pkg::REG_CTRL, rsx_pkg::CTRL_RST);
		#1;
		chk(instr_ready_o, 1'b1);
		chk(osc_stop_o, 1'b0);
		close_out();
	end
endmodule : testbench
`default_nettype wire
